// file: common/bps_map.svh
// Register map, reset values and timing counts of the protection sequencer.
// Contract
// - After disable, ignore new enable requests until 2 ms lockout has elapsed.
// - Regulate to the soft-start ramp while below 0.6 V, then the fixed reference.
// - Keep charging the ramp up to about 1.5 V after the reference takes over.
// - Rise time from zero to 95 percent is 0.065 ms per nanofarad.
// - Pre-charged output of 20 to 75 percent, at least 300 mV, rises monotonically.
// - Raise the power-in-range flag when rising output exceeds 92 percent.
// - Outside the 90 to 110 percent window, hold the flag 70 us, then drop.
// - Drop the power-in-range flag at once when output exceeds 110 percent.
// - High-side current above trip turns both switches off for the rest of cycle.
// - Eight consecutive trip cycles enter hiccup: off about 27 ms, then full soft-start.
// - Repeat hiccup disable and restart without limit while over-current persists.
// - Stop above about 150 C and resume with soft-start after 25 C cooling.
// - Inhibit switching until input passes upper threshold; stop below lower threshold.
// - Low-side on two full cycles leaves both switches off for next three cycles.
// - Switching frequency set externally within 0.7 MHz to 1.7 MHz.
// - Enable comparator stays active while disabled and is watched at all times.
`ifndef BPS_MAP_SVH
`define BPS_MAP_SVH
`define BPS_REG_CTRL 8'h00
`define BPS_REG_CYCLE 8'h04
`define BPS_REG_SSCAP 8'h08
`define BPS_REG_STATUS 8'h0C
`define BPS_CTRL_RST 1'h0
`define BPS_CYCLE_RST 9'h0D0
`define BPS_SSCAP_RST 8'h16
`define BPS_STS_PG_BIT 3
`define BPS_STS_UV_BIT 4
`define BPS_STS_FLOAT_BIT 5
`define BPS_STS_RAMP_LSB 16
`define BPS_RESP_OKAY 2'h0
`define BPS_RESP_SLVERR 2'h2
`define BPS_CLK_MHZ 250
`define BPS_FSW_MAX_MHZ_X10 17
`define BPS_FSW_MIN_MHZ_X10 7
`define BPS_CYCLE_MIN ((`BPS_CLK_MHZ * 10 + `BPS_FSW_MAX_MHZ_X10 - 1) / `BPS_FSW_MAX_MHZ_X10)
`define BPS_CYCLE_MAX (`BPS_CLK_MHZ * 10 / `BPS_FSW_MIN_MHZ_X10)
`define BPS_MS_CLKS (1000 * `BPS_CLK_MHZ)
`define BPS_LOCKOUT_MS 5'h02
`define BPS_HICCUP_MS 5'h1B
`define BPS_PG_DEGLITCH_US 70
`define BPS_PG_CLKS (`BPS_PG_DEGLITCH_US * `BPS_CLK_MHZ)
`define BPS_OC_STREAK 4'h8
`define BPS_REV_ON_CYCLES 2'h2
`define BPS_REV_FLOAT_CYCLES 2'h3
`define BPS_CODE_REF 10'h190
`define BPS_CODE_TOP 10'h3E8
`define BPS_CODE_PB_LO 10'h050
`define BPS_CODE_PB_HI 10'h12C
`define BPS_SS_US_PER_NF 65
`define BPS_RISE_CODES 380
`define BPS_SS_CLKS_PER_NF \
    ((`BPS_SS_US_PER_NF * `BPS_CLK_MHZ + `BPS_RISE_CODES - 1) / `BPS_RISE_CODES)
`endif

// file: common/bps_pkg.sv
// Types shared by the protection sequencer files.
package bps_pkg;
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_LOCK = 3'b001,
        ST_SS = 3'b010,
        ST_RUN = 3'b011,
        ST_HICCUP = 3'b100,
        ST_HOT = 3'b101
    } bps_state_e;
    typedef struct packed {
        logic enable_cmp;
        logic oc_cmp;
        logic temp_hot;
        logic temp_cool;
        logic vin_above_rise;
        logic vin_below_fall;
        logic vout_above_92;
        logic vout_below_90;
        logic vout_above_110;
        logic prebias_min_ok;
        logic pwm_demand;
    } bps_cmp_s;
endpackage

// file: design/bps_sync.sv
// Two-flop synchroniser for a bundle of comparator levels.
`timescale 1ns/1ns
module bps_sync #(
    parameter int W = 1
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Levels.
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// file: design/bps_top.sv
// Protection and start-up sequencer for a synchronous step-down stage.
`timescale 1ns/1ns
`include "bps_map.svh"
module bps_top import bps_pkg::*; #(
    parameter int unsigned MS_CLKS = `BPS_MS_CLKS,
    parameter int unsigned PG_CLKS = `BPS_PG_CLKS
) (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave.
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Analog front end.
    input wire bps_cmp_s cmp_raw,
    input wire logic [9:0] prebias_code,
    // Power stage and status.
    output logic hs_on,
    output logic ls_on,
    output logic power_in_range_flag,
    output logic [9:0] target_code
);
    // ==========================================================
    // Helpers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == `BPS_REG_CTRL || a == `BPS_REG_CYCLE || a == `BPS_REG_SSCAP ||
               a == `BPS_REG_STATUS;
    endfunction

    // ==========================================================
    // Input synchronisation
    logic [$bits(bps_cmp_s)-1:0] cs_bits;
    bps_cmp_s cs;
    bps_sync #(.W($bits(bps_cmp_s))) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .d(cmp_raw),
        .q(cs_bits)
    );
    assign cs = bps_cmp_s'(cs_bits);

    // ==========================================================
    // Registers and bus slave
    logic ctrl_en;
    logic [8:0] cycle_clks;
    logic [7:0] ss_cap;
    logic aw_full, w_full;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    bps_state_e st, next_st;
    logic [9:0] ramp;
    logic uv_ok;
    logic [1:0] float_left;
    wire aw_take = awvalid && awready;
    wire w_take = wvalid && wready;
    wire wr_do = aw_full && w_full && !bvalid;
    wire next_aw_full = (aw_full || aw_take) && !wr_do;
    wire next_w_full = (w_full || w_take) && !wr_do;
    wire next_bvalid = wr_do || (bvalid && !bready);
    wire ar_take = arvalid && arready;
    wire next_rvalid = ar_take || (rvalid && !rready);
    wire [31:0] cur_ctrl = {31'h0, ctrl_en};
    wire [31:0] cur_cycle = {23'h0, cycle_clks};
    wire [31:0] cur_sscap = {24'h0, ss_cap};
    wire [31:0] wr_ctrl = merge(cur_ctrl, w_data, w_strb);
    wire [31:0] wr_cycle = merge(cur_cycle, w_data, w_strb);
    wire [31:0] wr_sscap = merge(cur_sscap, w_data, w_strb);
    wire [31:0] status_word = {6'h0, ramp, 10'h0, float_left != 2'h0, uv_ok,
                               power_in_range_flag, st};
    wire [31:0] rd_word = (araddr == `BPS_REG_CTRL) ? cur_ctrl :
                          (araddr == `BPS_REG_CYCLE) ? cur_cycle :
                          (araddr == `BPS_REG_SSCAP) ? cur_sscap :
                          (araddr == `BPS_REG_STATUS) ? status_word : 32'h0;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `BPS_RESP_OKAY;
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0;
            rresp <= `BPS_RESP_OKAY;
            ctrl_en <= `BPS_CTRL_RST;
            cycle_clks <= `BPS_CYCLE_RST;
            ss_cap <= `BPS_SSCAP_RST;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            awready <= !next_aw_full && !next_bvalid;
            wready <= !next_w_full && !next_bvalid;
            bvalid <= next_bvalid;
            arready <= !next_rvalid;
            rvalid <= next_rvalid;
            if (aw_take) begin
                aw_addr <= awaddr;
            end
            if (w_take) begin
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (ar_take) begin
                rdata <= rd_word;
                rresp <= mapped(araddr) ? `BPS_RESP_OKAY : `BPS_RESP_SLVERR;
            end
            if (wr_do) begin
                bresp <= mapped(aw_addr) ? `BPS_RESP_OKAY : `BPS_RESP_SLVERR;
                if (aw_addr == `BPS_REG_CTRL) begin
                    ctrl_en <= wr_ctrl[0];
                end
                if (aw_addr == `BPS_REG_CYCLE) begin
                    cycle_clks <= wr_cycle[8:0];
                end
                if (aw_addr == `BPS_REG_SSCAP) begin
                    ss_cap <= wr_sscap[7:0];
                end
            end
        end
    end

    // ==========================================================
    // Switching cycle and millisecond base
    // The period is clamped so a bad register value cannot leave the allowed band.
    localparam logic [8:0] CYC_MIN = 9'(`BPS_CYCLE_MIN);
    localparam logic [8:0] CYC_MAX = 9'(`BPS_CYCLE_MAX);
    localparam logic [17:0] MS_LAST = 18'(MS_CLKS - 1);
    localparam logic [15:0] PG_LAST = 16'(PG_CLKS - 1);
    localparam logic [5:0] SS_PER_NF = 6'(`BPS_SS_CLKS_PER_NF);
    logic [8:0] cyc_cnt;
    logic [17:0] ms_cnt;
    logic [4:0] ms_left;
    wire [8:0] cyc_lim = (cycle_clks < CYC_MIN) ? CYC_MIN :
                         (cycle_clks > CYC_MAX) ? CYC_MAX : cycle_clks;
    wire cyc_end = cyc_cnt >= cyc_lim - 9'h1;
    wire ms_tick = ms_cnt == MS_LAST;
    wire st_change = next_st != st;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cyc_cnt <= 9'h0;
            ms_cnt <= 18'h0;
        end else begin
            cyc_cnt <= cyc_end ? 9'h0 : cyc_cnt + 9'h1;
            ms_cnt <= (ms_tick || st_change) ? 18'h0 : ms_cnt + 18'h1;
        end
    end

    // ==========================================================
    // Sequencing state machine
    logic [3:0] oc_streak;
    wire en_req = cs.enable_cmp && ctrl_en;
    wire want_on = en_req && uv_ok && !cs.temp_hot;
    wire running = st == ST_SS || st == ST_RUN;
    wire ms_done = ms_tick && ms_left == 5'h1;

    always_comb begin
        next_st = st;
        case (st)
            ST_OFF: if (want_on) begin
                next_st = ST_SS;
            end
            ST_LOCK: if (ms_done) begin
                next_st = ST_OFF;
            end
            ST_HICCUP: if (!en_req) begin
                next_st = ST_LOCK;
            end else if (ms_done) begin
                next_st = ST_SS;
            end
            ST_HOT: if (!en_req) begin
                next_st = ST_LOCK;
            end else if (cs.temp_cool && !cs.temp_hot) begin
                next_st = ST_SS;
            end
            ST_SS, ST_RUN: if (!en_req) begin
                next_st = ST_LOCK;
            end else if (cs.temp_hot) begin
                next_st = ST_HOT;
            end else if (!uv_ok) begin
                next_st = ST_OFF;
            end else if (oc_streak >= `BPS_OC_STREAK) begin
                next_st = ST_HICCUP;
            end else if (st == ST_SS && ramp >= `BPS_CODE_TOP) begin
                next_st = ST_RUN;
            end
            default: next_st = ST_OFF;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= ST_OFF;
            ms_left <= 5'h0;
            uv_ok <= 1'b0;
        end else begin
            st <= next_st;
            if (st_change && next_st == ST_LOCK) begin
                ms_left <= `BPS_LOCKOUT_MS;
            end else if (st_change && next_st == ST_HICCUP) begin
                ms_left <= `BPS_HICCUP_MS;
            end else if (ms_tick && ms_left != 5'h0) begin
                ms_left <= ms_left - 5'h1;
            end
            if (cs.vin_above_rise) begin
                uv_ok <= 1'b1;
            end else if (cs.vin_below_fall) begin
                uv_ok <= 1'b0;
            end
        end
    end

    // ==========================================================
    // Soft-start ramp and regulation target
    // A pre-charged output inside the pre-bias window starts the ramp at its own level, except on restart from hiccup; low side stays off until the
    // reference takes over so the output is never pulled down.
    logic [13:0] ss_cnt;
    logic pb_hold;
    wire [13:0] ss_last = 14'(ss_cap == 8'h0 ? 8'h1 : ss_cap) * 14'(SS_PER_NF) - 14'h1;
    wire ss_step = ss_cnt >= ss_last;
    wire ss_start = st_change && next_st == ST_SS;
    wire pb_ok = st != ST_HICCUP && cs.prebias_min_ok && prebias_code >= `BPS_CODE_PB_LO &&
                 prebias_code <= `BPS_CODE_PB_HI;
    wire [9:0] min_target = (ramp < `BPS_CODE_REF) ? ramp : `BPS_CODE_REF;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ramp <= 10'h0;
            ss_cnt <= 14'h0;
            pb_hold <= 1'b0;
            target_code <= 10'h0;
        end else begin
            target_code <= (running || ss_start) ? min_target : 10'h0;
            if (ss_start) begin
                ramp <= pb_ok ? prebias_code : 10'h0;
                pb_hold <= pb_ok;
                ss_cnt <= 14'h0;
            end else if (!running) begin
                ramp <= 10'h0;
                pb_hold <= 1'b0;
                ss_cnt <= 14'h0;
            end else begin
                ss_cnt <= ss_step ? 14'h0 : ss_cnt + 14'h1;
                if (ss_step && ramp < `BPS_CODE_TOP) begin
                    ramp <= ramp + 10'h1;
                end
                if (ramp >= `BPS_CODE_REF) begin
                    pb_hold <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // Current limits and gate drive
    logic oc_cut, ls_all;
    logic [1:0] ls_streak;
    wire oc_now = cs.oc_cmp && hs_on;
    wire oc_cycle = oc_cut || oc_now;
    wire ls_full = ls_all && ls_on;
    wire sw_ok = running && want_on && !oc_cut && !oc_now && float_left == 2'h0;
    wire next_hs = sw_ok && cs.pwm_demand;
    wire next_ls = sw_ok && !cs.pwm_demand && !pb_hold;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hs_on <= 1'b0;
            ls_on <= 1'b0;
            oc_cut <= 1'b0;
            oc_streak <= 4'h0;
            ls_all <= 1'b1;
            ls_streak <= 2'h0;
            float_left <= 2'h0;
        end else begin
            hs_on <= next_hs;
            ls_on <= next_ls;
            if (cyc_end) begin
                oc_cut <= 1'b0;
                ls_all <= 1'b1;
                if (!running) begin
                    oc_streak <= 4'h0;
                end else if (oc_cycle) begin
                    oc_streak <= (oc_streak >= `BPS_OC_STREAK) ? oc_streak : oc_streak + 4'h1;
                end else begin
                    oc_streak <= 4'h0;
                end
                if (float_left != 2'h0) begin
                    float_left <= float_left - 2'h1;
                end else if (ls_full && ls_streak + 2'h1 >= `BPS_REV_ON_CYCLES) begin
                    float_left <= `BPS_REV_FLOAT_CYCLES;
                end
                ls_streak <= (ls_full && ls_streak + 2'h1 < `BPS_REV_ON_CYCLES) ?
                             ls_streak + 2'h1 : 2'h0;
            end else begin
                oc_cut <= oc_cycle;
                ls_all <= ls_full;
            end
        end
    end

    // ==========================================================
    // Power-in-range flag with deglitch
    logic [15:0] pg_cnt;
    wire out_win = cs.vout_below_90 || cs.vout_above_110;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_in_range_flag <= 1'b0;
            pg_cnt <= 16'h0;
        end else if (!running || cs.vout_above_110) begin
            power_in_range_flag <= 1'b0;
            pg_cnt <= 16'h0;
        end else if (!power_in_range_flag) begin
            power_in_range_flag <= cs.vout_above_92;
            pg_cnt <= 16'h0;
        end else if (out_win) begin
            pg_cnt <= pg_cnt + 16'h1;
            if (pg_cnt >= PG_LAST) begin
                power_in_range_flag <= 1'b0;
            end
        end else begin
            pg_cnt <= 16'h0;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_lockout_holds: assert property ((st == ST_LOCK && !ms_done) |=> st == ST_LOCK)
        else $error("lockout left early");
    a_target_limit: assert property (running |=> target_code <= `BPS_CODE_REF)
        else $error("target above reference");
    a_ramp_top: assert property (st == ST_SS && ramp < `BPS_CODE_TOP |=> st != ST_RUN)
        else $error("run before ramp top");
    a_ramp_step: assert property ((st == ST_SS && next_st == ST_SS && ss_step &&
        ramp < `BPS_CODE_TOP) |=> ramp == $past(ramp) + 10'h1)
        else $error("ramp did not step");
    a_prebias_ls: assert property (pb_hold |=> !ls_on)
        else $error("low side on during pre-bias start");
    a_pg_rise: assert property ($rose(power_in_range_flag)
        |-> $past(cs.vout_above_92)) else $error("flag rose without 92 percent");
    a_pg_glitch: assert property ((power_in_range_flag && running && cs.vout_below_90 &&
        !cs.vout_above_110 && pg_cnt == 16'h0) |=> power_in_range_flag)
        else $error("flag dropped without deglitch");
    a_pg_over: assert property (cs.vout_above_110 |=> !power_in_range_flag)
        else $error("flag held above 110 percent");
    a_oc_cut: assert property (oc_now |=> !hs_on && !ls_on)
        else $error("switches on after trip");
    a_hiccup_entry: assert property ((running && oc_streak >= `BPS_OC_STREAK && want_on)
        |=> st == ST_HICCUP ##1 (!hs_on && !ls_on))
        else $error("no hiccup after trip streak");
    a_uv_hot_off: assert property ((!uv_ok || cs.temp_hot) |=> !hs_on && !ls_on)
        else $error("switching under lockout or heat");
    a_rev_float: assert property (float_left != 2'h0 |=> !hs_on && !ls_on)
        else $error("switch on while floating");
endmodule

// file: tb/bps_plant.sv
// Far-side model: comparators, sensed current and switching demand.
`timescale 1ns/1ns
module bps_plant import bps_pkg::*; (
    // Clock.
    input wire logic aclk,
    // Analog conditions set by the bench.
    input wire logic [1:0] vin,
    input wire logic en,
    input wire logic hot,
    input wire logic short,
    input wire logic lo,
    input wire logic pb,
    input wire logic [7:0] pct,
    // Gate feedback and comparator outputs.
    input wire logic hs_on,
    output bps_cmp_s cmp
);
    // ==========
    // Demand runs at a fixed 148-clock cycle, half on and half off.
    logic [7:0] t = 8'h00;
    always_ff @(posedge aclk) begin
        t <= (t == 8'h93) ? 8'h00 : t + 8'h01;
    end
    // Current is sensed only through a conducting high side.
    assign cmp = '{en, short & hs_on, hot, !hot, vin == 2'h2, vin == 2'h0,
        pct > 8'h5C, pct < 8'h5A, pct > 8'h6E, pb, !lo && t < 8'h4A};
endmodule

// file: tb/test_bps_top.sv
// Self-checking bench for the protection sequencer.
`timescale 1ns/1ns
module test_bps_top import bps_pkg::*;;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, pct = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rv;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, hs_on, ls_on, power_in_range_flag;
    logic [1:0] bresp, rresp, vin = 2'h0;
    logic [9:0] target_code, prebias_code = 10'h000;
    logic en = 1'b0, hot = 1'b0, short = 1'b0, lo = 1'b0, pb = 1'b0;
    logic [34:0] e, expq[$];
    bps_cmp_s cmp_raw;
    int n_mismatch = 0, compares = 0, cyc = 0, cnt = 0, t0 = 0, seed = 29;
    bps_top #(.MS_CLKS(50), .PG_CLKS(20)) DUT (.aclk(aclk), .aresetn(aresetn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .cmp_raw(cmp_raw), .prebias_code(prebias_code), .hs_on(hs_on), .ls_on(ls_on),
        .power_in_range_flag(power_in_range_flag), .target_code(target_code));
    bps_plant plant (.aclk(aclk), .vin(vin), .en(en), .hot(hot), .short(short), .lo(lo),
        .pb(pb), .pct(pct), .hs_on(hs_on), .cmp(cmp_raw));
    // ==========
    // Clock, timeout and read-result watcher.
    initial begin
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            n_mismatch++;
            complete_run();
        end
    end
    always @(posedge aclk) begin
        if (rvalid && rready) begin
            e = (expq.size() > 0) ? expq.pop_front() : 35'h7FFFFFFFF;
            if (e[34]) begin
                cmp_v("rdata", e[31:0], rdata);
                cmp_v("rresp", e[33:32], rresp);
            end
        end
    end
    // ==========
    // Shared tasks.
    task automatic cmp_v(input string nm, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        cmp_v("bresp", r, bresp);
    endtask
    // The expected word is queued; the watcher compares it at the handshake.
    task automatic rd(input logic [7:0] a, input logic [34:0] x);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        expq.push_back(x);
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rv = rdata;
    endtask
    task automatic wait_st(input logic [2:0] s, input int lim);
        cnt = 0;
        do begin
            rd(8'h0C, 35'h0);
            cnt++;
        end while (rv[2:0] !== s && cnt < lim);
        cmp_v("state", s, rv[2:0]);
    endtask
    task automatic wait_tc(input logic [9:0] v);
        cnt = 0;
        while (target_code !== v && cnt < 30000) begin
            @(posedge aclk);
            cnt++;
        end
    endtask
    task automatic complete_run;
        if (n_mismatch == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ==========
    // Main sequence.
    initial begin
        step(3);
        aresetn <= 1'b1;
        step(2);
        rd(8'h00, {3'h4, 32'h0});
        rd(8'h04, {3'h4, 32'h0D0});
        rd(8'h08, {3'h4, 32'h16});
        rd(8'h10, {3'h6, 32'h0});
        wr(8'h10, 32'h1, 2'h2);
        wr(8'h0C, 32'hFFFFFFFF, 2'h0);
        rd(8'h0C, {3'h4, 32'h0});
        wr(8'h08, 32'h1, 2'h0);
        wr(8'h04, 32'h94, 2'h0);
        wr(8'h00, $random(seed) | 32'h1, 2'h0);
        rd(8'h00, {3'h4, 32'h1});
        en <= 1'b1;
        vin <= 2'h1;
        step(20);
        cmp_v("gates", 0, {hs_on, ls_on});
        vin <= 2'h2;
        step(3);
        vin <= 2'h1;
        wait_st(3'h2, 8);
        wait_tc(10'h17C);
        cmp_v("rise", 1, cnt > 15900 && cnt < 16700);
        wait_tc(10'h190);
        step(500);
        cmp_v("target", 10'h190, target_code);
        wait_st(3'h3, 14000);
        cmp_v("ramp", 10'h3E8, rv[25:16]);
        pct <= 8'h5F;
        step(6);
        cmp_v("flag", 1, power_in_range_flag);
        pct <= 8'h55;
        step(12);
        cmp_v("flag", 1, power_in_range_flag);
        step(16);
        cmp_v("flag", 0, power_in_range_flag);
        pct <= 8'h5F;
        step(6);
        cmp_v("flag", 1, power_in_range_flag);
        pct <= 8'h73;
        step(6);
        cmp_v("flag", 0, power_in_range_flag);
        wait_tc(10'h190);
        while (hs_on !== 1'b0) @(posedge aclk);
        while (hs_on !== 1'b1) @(posedge aclk);
        short <= 1'b1;
        step(5);
        cmp_v("gates", 0, {hs_on, ls_on});
        short <= 1'b0;
        step(300);
        rd(8'h0C, 35'h0);
        cmp_v("state", 3, rv[2:0]);
        short <= 1'b1;
        wait_st(3'h4, 700);
        t0 = cyc;
        wait_st(3'h2, 800);
        cmp_v("hiccup", 1, cyc - t0 > 1330 && cyc - t0 < 1420);
        wait_st(3'h4, 700);
        short <= 1'b0;
        wait_st(3'h2, 800);
        cmp_v("restart", 1, target_code < 10'h00A);
        lo <= 1'b1;
        step(290);
        cnt = 0;
        while ({hs_on, ls_on} !== 2'h0 && cnt < 200) begin
            @(posedge aclk);
            cnt++;
        end
        cnt = 0;
        while ({hs_on, ls_on} === 2'h0 && cnt < 600) begin
            @(posedge aclk);
            cnt++;
        end
        cmp_v("float", 1, cnt > 440 && cnt < 448);
        lo <= 1'b0;
        hot <= 1'b1;
        wait_st(3'h5, 10);
        cmp_v("gates", 0, {hs_on, ls_on});
        hot <= 1'b0;
        wait_st(3'h2, 10);
        prebias_code <= 10'h0C8;
        pb <= 1'b1;
        en <= 1'b0;
        wait_st(3'h1, 10);
        en <= 1'b1;
        step(60);
        rd(8'h0C, 35'h0);
        cmp_v("state", 1, rv[2:0]);
        wait_st(3'h2, 40);
        cmp_v("prebias", 1, target_code >= 10'h0C8 && target_code < 10'h0D2);
        cmp_v("ls_on", 0, ls_on);
        complete_run();
    end
endmodule
